// ==== ais_aux_irq.sv ====
// Auxiliary interrupt controller with serial bit counter, I2C status and shared serial data register.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
module ais_aux_irq #(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Event sources
  input wire logic sec_tick,
  input wire logic millisecond_timer_flag_tick,
  input wire logic sum_done,
  input wire logic [7:0] sum_low_data,
  input wire logic conv_done,
  input wire logic [7:0] conv_low_data,
  input wire logic low_supply_detect,
  // Serial engine
  input wire logic bit_done,
  input wire logic i2c_start_det,
  input wire logic i2c_stop_det,
  input wire logic rx_load,
  input wire logic [7:0] rx_data,
  output logic [7:0] tx_data,
  output logic scl_stretch_allow,
  // Interrupt to the core
  output logic aux_irq,
  output logic [15:0] aux_vector_addr,
  output logic global_irq_enable
);
  import ais_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [3:0] count_code(input logic [3:0] n);
    case (n)
      4'h0: count_code = 4'h0;
      4'h1: count_code = 4'h1;
      4'h2: count_code = 4'h3;
      4'h3: count_code = 4'h2;
      4'h4: count_code = 4'h6;
      4'h5: count_code = 4'h7;
      4'h6: count_code = 4'h5;
      4'h7: count_code = 4'h4;
      default: count_code = 4'hc;
    endcase
  endfunction : count_code

  function automatic logic [3:0] prio_index(input logic [7:0] st);
    if (st[SRC_LOWV]) begin
      prio_index = PAI_LOWV;
    end else if (st[SRC_I2C]) begin
      prio_index = PAI_I2C;
    end else if (st[SRC_CNT]) begin
      prio_index = PAI_CNT;
    end else if (st[SRC_MILLISECOND_TIMER_FLAG]) begin
      prio_index = PAI_MILLISECOND_TIMER_FLAG;
    end else if (st[SRC_CONV]) begin
      prio_index = PAI_CONV;
    end else if (st[SRC_SUM]) begin
      prio_index = PAI_SUM;
    end else if (st[SRC_SEC]) begin
      prio_index = PAI_SEC;
    end else begin
      prio_index = PAI_NONE;
    end
  endfunction : prio_index

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic waitrequest_reg;
  logic waitrequest_next;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic [7:0] enable_reg;
  logic [7:0] ext_ctl_reg;
  logic [7:0] ie_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [7:0] conv_reg;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic cnt_sel_reg;
  logic stretch_dis_reg;
  logic stretch_dis_next;
  logic start_st_reg;
  logic stop_st_reg;
  logic sec_flag_reg;
  logic millisecond_timer_flag_flag_reg;
  logic sum_flag_reg;
  logic conv_flag_reg;
  logic i2c_flag_reg;
  logic cnt_flag_reg;
  logic lowv_flag_reg;
  logic aux_irq_reg;
  logic stretch_allow_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic req = avs_read | avs_write;
  wire logic acc = req & ~waitrequest_reg;
  wire logic [7:0] idx = avs_address[ADDR_W-1:2];
  wire logic aligned = (avs_address[1:0] == 2'b00);
  wire logic wr_lane = acc & avs_write & aligned & avs_byteenable[0];
  wire logic rd_acc = acc & avs_read & aligned;
  wire logic [7:0] wbyte = avs_writedata[7:0];
  wire logic hit_ctl = (idx == IDX_I2C_CONTROL_STATUS);
  wire logic hit_data = (idx == IDX_SERIAL_DATA);
  wire logic wr_ctl = wr_lane & hit_ctl;
  wire logic wr_data = wr_lane & hit_data;
  wire logic data_access = (rd_acc | (acc & avs_write & aligned)) & hit_data;
  wire logic rd_sec = rd_acc & (idx == IDX_SECONDS_TIMER_IRQ_REG);
  wire logic rd_millisecond_timer_flag = rd_acc & (idx == IDX_MILLISECOND_TIMER_IRQ_REG);
  wire logic rd_sum = rd_acc & (idx == IDX_SUMMATION_LOW_BYTE);
  wire logic rd_conv = rd_acc & (idx == IDX_CONVERSION_LOW_BYTE);

  // ----------------------------------------------------------------
  // Interrupt views
  // ----------------------------------------------------------------
  wire logic [7:0] poll_w = {sec_flag_reg, sum_flag_reg, conv_flag_reg, millisecond_timer_flag_flag_reg,
                             i2c_flag_reg, cnt_flag_reg, lowv_flag_reg, 1'b0};
  wire logic [7:0] status_w = poll_w & enable_reg;
  wire logic [3:0] pai_w = prio_index(status_w);
  wire logic [3:0] cnt_target = cnt_sel_reg ? BIT_COUNT_ONE : BIT_COUNT_FULL;
  wire logic bit_step = bit_done & (count_reg != BIT_COUNT_FULL);
  wire logic [3:0] count_inc = count_reg + 4'h1;
  wire logic cnt_hit = bit_step & (count_inc == cnt_target);
  wire logic [7:0] ctl_rd = {count_code(count_reg), stop_st_reg, start_st_reg,
                             stretch_dis_reg, cnt_sel_reg};
  // Group gate only; the global enable is deliberately left out so auxiliary sources stay live.
  wire logic aux_irq_next = ext_ctl_reg[EXT_AUX_GROUP_EN] & (|status_w);

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  assign waitrequest_next = ~(req & waitrequest_reg);
  // Restart wins over a bit edge in the same cycle so the next byte starts clean.
  assign count_next = data_access ? 4'h0 : (bit_step ? count_inc : count_reg);
  // A start clears the bit; a software write in the same cycle still lands.
  assign stretch_dis_next = wr_ctl ? wbyte[CTL_STRETCH_DIS] :
                            (i2c_start_det ? 1'b0 : stretch_dis_reg);

  always_comb begin
    readdata_next = 32'h0000_0000;
    if (avs_read & aligned) begin
      case (idx)
        IDX_I2C_CONTROL_STATUS: readdata_next[7:0] = ctl_rd;
        IDX_SERIAL_DATA: readdata_next[7:0] = rx_reg;
        IDX_AUX_IRQ_POLL: readdata_next[7:0] = poll_w;
        IDX_AUX_IRQ_PENDING_INDEX: readdata_next[7:0] = {4'h0, pai_w};
        IDX_AUX_IRQ_ENABLE: readdata_next[7:0] = enable_reg;
        IDX_AUX_IRQ_STATUS: readdata_next[7:0] = status_w;
        IDX_IRQ_ENABLE: readdata_next[7:0] = ie_reg;
        IDX_EXTENDED_IRQ_CONTROL: readdata_next[7:0] = ext_ctl_reg;
        IDX_CONVERSION_LOW_BYTE: readdata_next[7:0] = conv_reg;
        IDX_SUMMATION_LOW_BYTE: readdata_next[7:0] = sum_low_data;
        IDX_SECONDS_TIMER_IRQ_REG: readdata_next[7:0] = {7'h00, sec_flag_reg};
        IDX_MILLISECOND_TIMER_IRQ_REG: readdata_next[7:0] = {7'h00, millisecond_timer_flag_flag_reg};
        default: readdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus and software registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h0000_0000;
      enable_reg <= RESET_BYTE;
      ext_ctl_reg <= RESET_BYTE;
      ie_reg <= RESET_BYTE;
      tx_reg <= RESET_BYTE;
      cnt_sel_reg <= 1'b0;
    end else begin
      waitrequest_reg <= waitrequest_next;
      readdata_reg <= readdata_next;
      if (wr_lane & (idx == IDX_AUX_IRQ_ENABLE)) begin
        enable_reg <= wbyte & AUX_SRC_MASK;
      end
      if (wr_lane & (idx == IDX_EXTENDED_IRQ_CONTROL)) begin
        ext_ctl_reg <= wbyte;
      end
      if (wr_lane & (idx == IDX_IRQ_ENABLE)) begin
        ie_reg <= wbyte;
      end
      if (wr_data) begin
        tx_reg <= wbyte;
      end
      if (wr_ctl) begin
        cnt_sel_reg <= wbyte[CTL_CNT_SEL];
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial counter, I2C status and data buffers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      count_reg <= 4'h0;
      stretch_dis_reg <= 1'b0;
      start_st_reg <= 1'b0;
      stop_st_reg <= 1'b0;
      rx_reg <= RESET_BYTE;
      conv_reg <= RESET_BYTE;
    end else begin
      count_reg <= count_next;
      stretch_dis_reg <= stretch_dis_next;
      start_st_reg <= i2c_start_det | (start_st_reg & ~wr_data);
      stop_st_reg <= i2c_stop_det | (stop_st_reg & ~wr_data);
      if (rx_load) begin
        rx_reg <= rx_data;
      end
      // Results arriving while the flag is up are dropped; the unread value is never torn.
      if (conv_done & ~conv_flag_reg) begin
        conv_reg <= conv_low_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Source flags (a set in the clearing cycle wins)
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sec_flag_reg <= 1'b0;
      millisecond_timer_flag_flag_reg <= 1'b0;
      sum_flag_reg <= 1'b0;
      conv_flag_reg <= 1'b0;
      i2c_flag_reg <= 1'b0;
      cnt_flag_reg <= 1'b0;
      lowv_flag_reg <= 1'b0;
    end else begin
      sec_flag_reg <= sec_tick | (sec_flag_reg & ~rd_sec);
      millisecond_timer_flag_flag_reg <= millisecond_timer_flag_tick | (millisecond_timer_flag_flag_reg & ~rd_millisecond_timer_flag);
      sum_flag_reg <= sum_done | (sum_flag_reg & ~rd_sum);
      conv_flag_reg <= conv_done | (conv_flag_reg & ~rd_conv);
      i2c_flag_reg <= i2c_start_det | i2c_stop_det | (i2c_flag_reg & ~wr_data);
      cnt_flag_reg <= cnt_hit | (cnt_flag_reg & ~data_access);
      lowv_flag_reg <= low_supply_detect;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      aux_irq_reg <= 1'b0;
      stretch_allow_reg <= 1'b0;
    end else begin
      aux_irq_reg <= aux_irq_next;
      stretch_allow_reg <= ~stretch_dis_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      aux_vector_addr <= AUX_VECTOR_ADDR;
    end else begin
      aux_vector_addr <= AUX_VECTOR_ADDR;
    end
  end

  assign avs_waitrequest = waitrequest_reg;
  assign avs_readdata = readdata_reg;
  assign tx_data = tx_reg;
  assign aux_irq = aux_irq_reg;
  assign scl_stretch_allow = stretch_allow_reg;
  assign global_irq_enable = ie_reg[IE_GLOBAL];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_status_masked: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_acc & (idx == IDX_AUX_IRQ_STATUS) |-> avs_readdata[7:0] == $past(poll_w & enable_reg))
    else $error("status is not poll and mask");
  a_lowv_first: assert property (@(posedge sys_clk) disable iff (!rst_b)
    status_w[SRC_LOWV] |-> pai_w == PAI_LOWV) else $error("low voltage not highest");
  a_sec_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (status_w == 8'h80) |-> pai_w == PAI_SEC) else $error("seconds index wrong");
  a_sec_read_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_sec & ~sec_tick |=> !sec_flag_reg) else $error("seconds flag not cleared");
  a_cnt_raise: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bit_done & (count_reg == 4'h7) & ~cnt_sel_reg |=> cnt_flag_reg) else $error("count irq missing");
  a_data_restart: assert property (@(posedge sys_clk) disable iff (!rst_b)
    data_access |=> (count_reg == 4'h0) && (cnt_flag_reg == $past(cnt_hit)))
    else $error("data access did not restart");
  a_conv_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    conv_flag_reg |=> $stable(conv_reg)) else $error("result overwritten while pending");
  a_start_status: assert property (@(posedge sys_clk) disable iff (!rst_b)
    i2c_start_det & ~wr_ctl |=> start_st_reg && !stretch_dis_reg) else $error("start not recorded");
  a_irq_group: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ext_ctl_reg[EXT_AUX_GROUP_EN] |=> !aux_irq_reg) else $error("group gate ignored");
  a_lowv_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !low_supply_detect |=> !lowv_flag_reg) else $error("low voltage flag stuck");
  a_tx_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_data |=> tx_data == $past(avs_writedata[7:0])) else $error("tx buffer not loaded");
endmodule : ais_aux_irq

// ==== ais_aux_irq_tb_top.sv ====
// Self-checking testbench for the auxiliary interrupt block.
`timescale 1ns/1ps
module ais_aux_irq_tb_top;
  import ais_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk;
  logic rst_b;
  logic [9:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // Event strobes: sec, millisecond_timer_flag, sum, conv, start, stop, bit done, rx load.
  logic [7:0] ev;
  logic low_supply_detect;
  logic [7:0] sum_low_data;
  logic [7:0] conv_low_data;
  logic [7:0] rx_data;
  logic [7:0] tx_data;
  logic scl_stretch_allow;
  logic aux_irq;
  logic [15:0] aux_vector_addr;
  logic global_irq_enable;
  logic [31:0] rdata;
  int miscompares;
  int n_checks;
  int cycles;
  localparam logic [3:0] CODE_TAB [0:8] = '{4'h0, 4'h1, 4'h3, 4'h2, 4'h6, 4'h7, 4'h5, 4'h4, 4'hc};

  ais_aux_irq #(.ADDR_W(10)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sec_tick(ev[0]),
    .millisecond_timer_flag_tick(ev[1]), .sum_done(ev[2]), .sum_low_data(sum_low_data), .conv_done(ev[3]),
    .conv_low_data(conv_low_data), .low_supply_detect(low_supply_detect), .bit_done(ev[6]),
    .i2c_start_det(ev[4]), .i2c_stop_det(ev[5]), .rx_load(ev[7]), .rx_data(rx_data),
    .tx_data(tx_data), .scl_stretch_allow(scl_stretch_allow), .aux_irq(aux_irq),
    .aux_vector_addr(aux_vector_addr), .global_irq_enable(global_irq_enable)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // The request is held until waitrequest is sampled low; only the bench timeout ends a hang.
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    int waits;
    waits = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !we;
    avs_write <= we;
    avs_writedata <= {24'h000000, wd};
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      waits++;
      @(posedge sys_clk);
    end
    rdata = avs_readdata;
    check(32'(waits), 32'h00000001);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rdata, {24'h000000, exp});
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask : wr

  task automatic pulse(input logic [7:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 8'h00;
  endtask : pulse

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Clock, timeout and test sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // The whole sequence needs well under a thousand cycles.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    rst_b = 1'b0;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hf;
    avs_writedata = 32'h00000000;
    ev = 8'h00;
    low_supply_detect = 1'b0;
    sum_low_data = 8'h3c;
    conv_low_data = 8'h11;
    rx_data = 8'h00;
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(IDX_I2C_CONTROL_STATUS, 8'h00);
    rd(IDX_AUX_IRQ_POLL, 8'h00);
    rd(IDX_AUX_IRQ_PENDING_INDEX, 8'h00);
    rd(IDX_AUX_IRQ_STATUS, 8'h00);
    rd(8'h10, 8'h00);
    check({16'h0000, aux_vector_addr}, 32'h00000033);
    wr(IDX_AUX_IRQ_ENABLE, 8'hff);
    rd(IDX_AUX_IRQ_ENABLE, 8'hfe);
    avs_byteenable <= 4'h0;
    wr(IDX_AUX_IRQ_ENABLE, 8'h00);
    avs_byteenable <= 4'hf;
    rd(IDX_AUX_IRQ_ENABLE, 8'hfe);
    $display("test reset_and_enable done");
    wr(IDX_EXTENDED_IRQ_CONTROL, 8'h10);
    low_supply_detect <= 1'b1;
    pulse(8'h1f);
    repeat (8) pulse(8'h40);
    idle(2);
    rd(IDX_AUX_IRQ_POLL, 8'hfe);
    rd(IDX_AUX_IRQ_STATUS, 8'hfe);
    check(32'(aux_irq), 32'h00000001);
    check(32'(global_irq_enable), 32'h00000000);
    rd(IDX_AUX_IRQ_PENDING_INDEX, {4'h0, PAI_LOWV});
    low_supply_detect <= 1'b0;
    idle(2);
    rd(IDX_AUX_IRQ_PENDING_INDEX, {4'h0, PAI_I2C});
    rd(IDX_SERIAL_DATA, 8'h00);
    rd(IDX_AUX_IRQ_STATUS, 8'hf8);
    rd(IDX_AUX_IRQ_PENDING_INDEX, {4'h0, PAI_I2C});
    wr(IDX_SERIAL_DATA, 8'h5a);
    idle(1);
    check({24'h000000, tx_data}, 32'h0000005a);
    rd(IDX_AUX_IRQ_PENDING_INDEX, {4'h0, PAI_MILLISECOND_TIMER_FLAG});
    rd(IDX_MILLISECOND_TIMER_IRQ_REG, 8'h01);
    rd(IDX_AUX_IRQ_PENDING_INDEX, {4'h0, PAI_CONV});
    rd(IDX_CONVERSION_LOW_BYTE, 8'h11);
    rd(IDX_AUX_IRQ_PENDING_INDEX, {4'h0, PAI_SUM});
    rd(IDX_SUMMATION_LOW_BYTE, 8'h3c);
    rd(IDX_AUX_IRQ_PENDING_INDEX, {4'h0, PAI_SEC});
    rd(IDX_SECONDS_TIMER_IRQ_REG, 8'h01);
    rd(IDX_AUX_IRQ_PENDING_INDEX, {4'h0, PAI_NONE});
    idle(3);
    check(32'(aux_irq), 32'h00000000);
    $display("test priority_and_clears done");
    pulse(8'h03);
    wr(IDX_AUX_IRQ_ENABLE, 8'h00);
    rd(IDX_AUX_IRQ_STATUS, 8'h00);
    rd(IDX_AUX_IRQ_POLL, 8'h90);
    idle(3);
    check(32'(aux_irq), 32'h00000000);
    wr(IDX_AUX_IRQ_ENABLE, 8'h90);
    wr(IDX_EXTENDED_IRQ_CONTROL, 8'h00);
    idle(3);
    check(32'(aux_irq), 32'h00000000);
    wr(IDX_EXTENDED_IRQ_CONTROL, 8'h10);
    wr(IDX_IRQ_ENABLE, 8'h80);
    idle(3);
    check(32'(aux_irq), 32'h00000001);
    check(32'(global_irq_enable), 32'h00000001);
    rd(IDX_SECONDS_TIMER_IRQ_REG, 8'h01);
    rd(IDX_MILLISECOND_TIMER_IRQ_REG, 8'h01);
    conv_low_data <= 8'h22;
    pulse(8'h08);
    conv_low_data <= 8'h33;
    pulse(8'h08);
    rd(IDX_CONVERSION_LOW_BYTE, 8'h22);
    rd(IDX_AUX_IRQ_POLL, 8'h00);
    $display("test masking_and_group done");
    rd(IDX_SERIAL_DATA, 8'h00);
    rd(IDX_I2C_CONTROL_STATUS, 8'h00);
    for (int k = 1; k <= 8; k++) begin
      pulse(8'h40);
      bus(1'b0, IDX_I2C_CONTROL_STATUS, 8'h00);
      check({28'h0000000, rdata[7:4]}, {28'h0000000, CODE_TAB[k]});
      bus(1'b0, IDX_AUX_IRQ_POLL, 8'h00);
      check(32'(rdata[SRC_CNT]), 32'(k == 8));
    end
    wr(IDX_I2C_CONTROL_STATUS, 8'h01);
    rd(IDX_SERIAL_DATA, 8'h00);
    rd(IDX_AUX_IRQ_POLL, 8'h00);
    pulse(8'h40);
    rd(IDX_AUX_IRQ_POLL, 8'h04);
    rd(IDX_I2C_CONTROL_STATUS, 8'h11);
    wr(IDX_I2C_CONTROL_STATUS, 8'h00);
    rx_data <= 8'ha5;
    pulse(8'h80);
    rd(IDX_SERIAL_DATA, 8'ha5);
    $display("test bit_count done");
    pulse(8'h10);
    rd(IDX_I2C_CONTROL_STATUS, 8'h04);
    pulse(8'h20);
    rd(IDX_I2C_CONTROL_STATUS, 8'h0c);
    rd(IDX_AUX_IRQ_POLL, 8'h08);
    wr(IDX_SERIAL_DATA, 8'h00);
    rd(IDX_I2C_CONTROL_STATUS, 8'h00);
    rd(IDX_AUX_IRQ_POLL, 8'h00);
    wr(IDX_I2C_CONTROL_STATUS, 8'h02);
    idle(2);
    check(32'(scl_stretch_allow), 32'h00000000);
    rd(IDX_I2C_CONTROL_STATUS, 8'h02);
    pulse(8'h10);
    idle(2);
    check(32'(scl_stretch_allow), 32'h00000001);
    rd(IDX_I2C_CONTROL_STATUS, 8'h04);
    $display("test i2c_status done");
    stop_test();
  end
endmodule : ais_aux_irq_tb_top

// ==== ais_pkg.sv ====
// Package with register indices, field positions and reset values of the auxiliary interrupt block.
// Functional notes
// - Bit count read back in odd sequence
// - Count interrupt at eight, or one if selected
// - Stop status set on stop, cleared by data write
// - Start status set on start, cleared by data write
// - Stretch disable bit, cleared by start condition
// - Separate transmit and receive buffers, one address
// - Poll register shows unmasked requests per source
// - Pending index encodes highest pending source
// - All auxiliary sources share one vector
// - Low voltage highest, seconds timer lowest priority
// - Enable register holds readable mask bits
// - Group enable bit four gates all sources
// - Status flag is request and mask
// - Seconds flag cleared by reading its register
// - Summation flag cleared by reading low byte
// - Converter flag cleared on read, blocks result update
// - Millisecond flag cleared by reading its register
// - Start/stop flag cleared by data write
// - Count flag cleared by any data access
// - Low voltage flag follows supply in hardware
// - Global enable does not gate auxiliary sources
package ais_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_I2C_CONTROL_STATUS = 8'h9a;
  localparam logic [7:0] IDX_SERIAL_DATA = 8'h9b;
  localparam logic [7:0] IDX_AUX_IRQ_POLL = 8'ha4;
  localparam logic [7:0] IDX_AUX_IRQ_PENDING_INDEX = 8'ha5;
  localparam logic [7:0] IDX_AUX_IRQ_ENABLE = 8'ha6;
  localparam logic [7:0] IDX_AUX_IRQ_STATUS = 8'ha7;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'ha8;
  localparam logic [7:0] IDX_EXTENDED_IRQ_CONTROL = 8'hd8;
  localparam logic [7:0] IDX_CONVERSION_LOW_BYTE = 8'hd9;
  localparam logic [7:0] IDX_SUMMATION_LOW_BYTE = 8'he2;
  localparam logic [7:0] IDX_SECONDS_TIMER_IRQ_REG = 8'hf9;
  localparam logic [7:0] IDX_MILLISECOND_TIMER_IRQ_REG = 8'hfa;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SRC_SEC = 7;
  localparam int SRC_SUM = 6;
  localparam int SRC_CONV = 5;
  localparam int SRC_MILLISECOND_TIMER_FLAG = 4;
  localparam int SRC_I2C = 3;
  localparam int SRC_CNT = 2;
  localparam int SRC_LOWV = 1;
  localparam int CTL_STOP = 3;
  localparam int CTL_START = 2;
  localparam int CTL_STRETCH_DIS = 1;
  localparam int CTL_CNT_SEL = 0;
  localparam int EXT_AUX_GROUP_EN = 4;
  localparam int IE_GLOBAL = 7;
  localparam logic [7:0] AUX_SRC_MASK = 8'hfe;
  // ----------------------------------------------------------------
  // Counts, codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
  localparam logic [3:0] BIT_COUNT_ONE = 4'h1;
  localparam logic [15:0] AUX_VECTOR_ADDR = 16'h0033;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] PAI_NONE = 4'h0;
  localparam logic [3:0] PAI_LOWV = 4'h2;
  localparam logic [3:0] PAI_I2C = 4'h3;
  localparam logic [3:0] PAI_CNT = 4'h4;
  localparam logic [3:0] PAI_MILLISECOND_TIMER_FLAG = 4'h5;
  localparam logic [3:0] PAI_CONV = 4'h6;
  localparam logic [3:0] PAI_SUM = 4'h7;
  localparam logic [3:0] PAI_SEC = 4'h8;
endpackage : ais_pkg
